// ==== sim/mb_master_model.sv ====
`include "mb_defs.svh"
module mb_master_model (
    input  wire logic       sys_clk,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_end,
    output logic            tx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] got [$];
    int         frames = 0;
    logic [1:0] stall_cnt = 2'h0;

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_end   = 1'b0;
    end

    function automatic logic [15:0] crc16(input logic [7:0] f [$]);
        logic [15:0] c;
        c = `MB_CRC_INIT;
        foreach (f[i]) begin
            c ^= {8'h00, f[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ `MB_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // one byte per edge, crc low byte first, then the end-of-frame pulse
    task automatic send(input logic [7:0] f [$], input bit bad_crc);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0000, bad_crc};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(posedge sys_clk);
            rx_valid <= 1'b1;
            rx_data  <= f[i];
        end
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
        rx_end   <= 1'b1;
        @(posedge sys_clk);
        rx_end   <= 1'b0;
    endtask

    task automatic collect(input int lim, output logic [7:0] r [$]);
        int n0;
        n0 = frames;
        got.delete();
        repeat (lim) begin
            @(posedge sys_clk);
            if (frames != n0) break;
        end
        r = got;
    endtask

    // sink stalls one cycle in four
    always @(posedge sys_clk) begin
        stall_cnt <= stall_cnt + 2'h1;
        tx_ready  <= (stall_cnt != 2'h0);
        if (tx_valid === 1'b1 && tx_ready) begin
            got.push_back(tx_data);
            if (tx_last) frames <= frames + 1;
        end
    end
endmodule

// ==== sim/tb_modbus_rtu_slave_frames.sv ====
`include "mb_defs.svh"
module tb_modbus_rtu_slave_frames;
    import mb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [95:0] q;
        logic [3:0]  ql;
        logic [63:0] r;
        logic [3:0]  rl;
    } case_row_t;

    logic        sys_clk, srst, rx_valid, rx_end, tx_valid, tx_last, tx_ready, busy_on;
    logic [7:0]  station_id_setting, rx_data, tx_data;
    par_cmd_t    par_cmd;
    par_resp_t   par_resp = '0;
    logic [15:0] mem [256];
    case_row_t   rows [10];
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            results();
        end
    end

    // parameter area: address 0x00ff answers with an address error
    always @(posedge sys_clk) begin
        if (par_cmd.req && !par_resp.ack) begin
            par_resp <= '{1'b1, busy_on, par_cmd.addr == 16'h00ff, 1'b0, mem[par_cmd.addr[7:0]]};
            if (par_cmd.we && !busy_on && par_cmd.addr != 16'h00ff)
                mem[par_cmd.addr[7:0]] <= par_cmd.wdata;
        end else begin
            par_resp <= '{1'b0, 1'b0, 1'b0, 1'b0, ~par_resp.rdata};
        end
    end

    modbus_rtu_slave_frames u_dut (
        .sys_clk            (sys_clk),
        .srst               (srst),
        .station_id_setting (station_id_setting),
        .rx_valid           (rx_valid),
        .rx_data            (rx_data),
        .rx_end             (rx_end),
        .tx_valid           (tx_valid),
        .tx_data            (tx_data),
        .tx_last            (tx_last),
        .tx_ready           (tx_ready),
        .par_cmd            (par_cmd),
        .par_resp           (par_resp)
    );

    mb_master_model u_master (
        .sys_clk  (sys_clk),
        .rx_valid (rx_valid),
        .rx_data  (rx_data),
        .rx_end   (rx_end),
        .tx_ready (tx_ready),
        .tx_valid (tx_valid),
        .tx_data  (tx_data),
        .tx_last  (tx_last)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic run(input logic [95:0] qv, input int ql, input logic [63:0] rv,
                       input int rl, input bit bad);
        logic [7:0]  q [$];
        logic [7:0]  e [$];
        logic [7:0]  g [$];
        logic [15:0] c;
        for (int i = 0; i < ql; i++) q.push_back(qv[95-8*i -: 8]);
        for (int i = 0; i < rl; i++) e.push_back(rv[63-8*i -: 8]);
        if (rl > 0) begin
            c = u_master.crc16(e);
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
        end
        u_master.send(q, bad);
        u_master.collect(rl > 0 ? 3000 : 300, g);
        chk(g.size(), e.size());
        foreach (e[i]) if (i < g.size()) chk({24'h000000, g[i]}, {24'h000000, e[i]});
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        srst = 1'b1;
        station_id_setting = 8'h11;
        busy_on = 1'b0;
        for (int k = 0; k < 256; k++) mem[k] = {k[7:0] ^ 8'h5a, k[7:0]};
        rows = '{
            '{96'h11_03_00_10_00_02_000000000000, 4'd6, 64'h11_03_04_4b_11_48_12_00, 4'd7},
            '{96'h11_04_00_00_00_01_000000000000, 4'd6, 64'h11_04_02_5b_01_000000, 4'd5},
            '{96'h11_06_00_20_be_ef_000000000000, 4'd6, 64'h11_06_00_20_be_ef_0000, 4'd6},
            '{96'h11_10_00_30_00_02_04_12_34_56_78_00, 4'd11, 64'h11_10_00_30_00_02_0000, 4'd6},
            '{96'h11_07_00_00_00_01_000000000000, 4'd6, 64'h11_87_01_0000000000, 4'd3},
            '{96'h11_03_00_10_00_00_000000000000, 4'd6, 64'h11_83_03_0000000000, 4'd3},
            '{96'h11_03_00_fe_00_01_000000000000, 4'd6, 64'h11_83_02_0000000000, 4'd3},
            '{96'h11_10_00_40_00_01_03_aa_bb_cc_0000, 4'd10, 64'h11_90_03_0000000000, 4'd3},
            '{96'h11_04_00_00_00_7e_000000000000, 4'd6, 64'h11_84_03_0000000000, 4'd3},
            '{96'h11_04_00_00_00_00_000000000000, 4'd6, 64'h11_84_03_0000000000, 4'd3}
        };
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({31'h0, tx_valid}, 32'h0);
        chk({29'h0, par_cmd[34:32]}, 32'h0);
        foreach (rows[i]) run(rows[i].q, rows[i].ql, rows[i].r, rows[i].rl, 1'b0);
        // written words read back at field plus one
        run(96'h11_03_00_20_00_01_000000000000, 6, 64'h11_03_02_be_ef_000000, 5, 0);
        run(96'h11_03_00_30_00_02_000000000000, 6, 64'h11_03_04_12_34_56_78_00, 7, 0);
        run(96'h22_03_00_10_00_01_000000000000, 6, 64'h0, 0, 0);
        run(96'h11_03_00_10_00_01_000000000000, 6, 64'h0, 0, 1);
        busy_on <= 1'b1;
        run(96'h11_06_00_01_00_05_000000000000, 6, 64'h11_86_06_0000000000, 3, 0);
        busy_on <= 1'b0;
        // failing second word leaves the first word written
        run(96'h11_10_00_fd_00_02_04_0a_0b_0c_0d_00, 11, 64'h11_90_02_0000000000, 3, 0);
        chk({16'h0, mem[8'hfe]}, 32'h00000a0b);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({31'h0, tx_valid}, 32'h0);
        run(rows[1].q, rows[1].ql, rows[1].r, rows[1].rl, 1'b0);
        results();
    end
endmodule

// ==== verilog/mb_defs.svh ====
`ifndef MB_DEFS_SVH
`define MB_DEFS_SVH

`define MB_FC_RD_HOLD   8'h03
`define MB_FC_RD_INPUT  8'h04
`define MB_FC_WR_SINGLE 8'h06
`define MB_FC_WR_MULTI  8'h10
`define MB_EXC_FUNC     8'h01
`define MB_EXC_ADDR     8'h02
`define MB_EXC_VALUE    8'h03
`define MB_EXC_BUSY     8'h06
`define MB_EXC_FLAG     8'h80
`define MB_CRC_INIT     16'hffff
`define MB_CRC_POLY     16'ha001
`define MB_MAX_READ     16'h007d
`define MB_MAX_WRITE    16'h007b
`define MB_FIXED_LEN    9'h008
`define MB_MULTI_HDR    9'h009
`define MB_WR_RESP_LEN  9'h006
`define MB_HDR_LEN      9'h003
`define MB_MIN_LEN      9'h004
`define MB_BUF_DEPTH    256

`endif

// ==== verilog/mb_pkg.sv ====
package mb_pkg;
    typedef enum logic [5:0] {
        S_RECV  = 6'h01,
        S_CHECK = 6'h02,
        S_ISSUE = 6'h04,
        S_WAIT  = 6'h08,
        S_BUILD = 6'h10,
        S_SEND  = 6'h20
    } mb_state_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } par_cmd_t;

    typedef struct packed {
        logic        ack;
        logic        busy;
        logic        addr_err;
        logic        val_err;
        logic [15:0] rdata;
    } par_resp_t;
endpackage

// ==== verilog/modbus_rtu_slave_frames.sv ====
// Functional notes
// - accept only frames whose first byte is our station id; echo it first.
// - two-byte address field, high byte first, addresses the parameter area.
// - function 03 request and reply layout with byte count and data pairs.
// - function 04 request is station, function, address, count, crc lo/hi.
// - function 06 writes one register then echoes the request with new crc.
// - function 10 writes consecutive words; reply is address, count and crc.
// - exception codes 01 function, 02 address, 03 value, 06 busy.
// - exception reply is station, function with top bit set, code, crc.
`include "mb_defs.svh"
module modbus_rtu_slave_frames import mb_pkg::*; (
    input  wire logic      sys_clk,
    input  wire logic      srst,
    input  wire logic [7:0] station_id_setting,
    input  wire logic      rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic      rx_end,
    output logic           tx_valid,
    output logic [7:0]     tx_data,
    output logic           tx_last,
    input  wire logic      tx_ready,
    output par_cmd_t       par_cmd,
    input  wire par_resp_t par_resp
);
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MB_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    logic [7:0]  rxb [`MB_BUF_DEPTH];
    logic [7:0]  txb [`MB_BUF_DEPTH];
    mb_state_t   state_r;
    logic [8:0]  rx_cnt_r;
    logic [15:0] rx_crc_r;
    logic        ovf_r;
    logic [7:0]  fc_r;
    logic [15:0] addr_r;
    logic [15:0] qty_r;
    logic [7:0]  exc_r;
    logic [7:0]  idx_r;
    logic [8:0]  tx_len_r;
    logic [8:0]  tx_ptr_r;
    logic [15:0] tx_crc_r;
    logic        tx_valid_r;
    logic [7:0]  tx_data_r;
    par_cmd_t    par_cmd_r;

    logic        frame_ok;
    logic [7:0]  fc_in;
    logic [15:0] qty_in;
    logic [8:0]  len_multi;
    logic        is_read;
    logic        is_write;
    logic        last_item;
    logic        tx_hs;
    logic [15:0] tx_crc_nxt;
    logic [8:0]  tx_ptr_nxt;

    assign fc_in     = rxb[1];
    assign qty_in    = {rxb[4], rxb[5]};
    assign len_multi = `MB_MULTI_HDR + {qty_in[7:0], 1'b0};
    assign frame_ok  = !ovf_r && rx_cnt_r >= `MB_MIN_LEN && rx_crc_r == 16'h0000
                       && rxb[0] == station_id_setting;
    assign is_read   = fc_r == `MB_FC_RD_HOLD || fc_r == `MB_FC_RD_INPUT;
    assign is_write  = fc_r == `MB_FC_WR_SINGLE || fc_r == `MB_FC_WR_MULTI;
    assign last_item = fc_r == `MB_FC_WR_SINGLE || {8'h00, idx_r} + 16'h0001 == qty_r;
    assign tx_hs     = tx_valid_r && tx_ready;
    assign tx_ptr_nxt = tx_ptr_r + 9'h001;
    assign tx_crc_nxt = (tx_ptr_r < tx_len_r) ? crc_upd(tx_crc_r, tx_data_r) : tx_crc_r;

    assign tx_valid = tx_valid_r;
    assign tx_data  = tx_data_r;
    assign tx_last  = tx_valid_r && tx_ptr_r == tx_len_r + 9'h001;
    assign par_cmd  = par_cmd_r;

    // receive side: store bytes and run the crc over the whole frame
    always_ff @(posedge sys_clk) begin
        if (srst || state_r == S_CHECK) begin
            rx_cnt_r <= 9'h000;
            rx_crc_r <= `MB_CRC_INIT;
            ovf_r    <= 1'b0;
        end else if (state_r == S_RECV && rx_valid && !rx_end) begin
            rx_crc_r <= crc_upd(rx_crc_r, rx_data);
            if (rx_cnt_r == 9'(`MB_BUF_DEPTH)) begin
                ovf_r <= 1'b1;
            end else begin
                rx_cnt_r <= rx_cnt_r + 9'h001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (state_r == S_RECV && rx_valid && !rx_end && rx_cnt_r < 9'(`MB_BUF_DEPTH)) begin
            rxb[rx_cnt_r[7:0]] <= rx_data;
        end
    end

    // request decode and sequencing
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r   <= S_RECV;
            fc_r      <= 8'h00;
            addr_r    <= 16'h0000;
            qty_r     <= 16'h0000;
            exc_r     <= 8'h00;
            idx_r     <= 8'h00;
            par_cmd_r <= '0;
        end else begin
            case (state_r)
                S_RECV: begin
                    if (rx_end) begin
                        state_r <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    fc_r   <= fc_in;
                    addr_r <= {rxb[2], rxb[3]};
                    qty_r  <= qty_in;
                    idx_r  <= 8'h00;
                    exc_r  <= 8'h00;
                    if (!frame_ok) begin
                        state_r <= S_RECV;
                    end else begin
                        case (fc_in)
                            `MB_FC_RD_HOLD, `MB_FC_RD_INPUT: begin
                                if (rx_cnt_r != `MB_FIXED_LEN || qty_in == 16'h0000
                                    || qty_in > `MB_MAX_READ) begin
                                    exc_r   <= `MB_EXC_VALUE;
                                    state_r <= S_BUILD;
                                end else begin
                                    state_r <= S_ISSUE;
                                end
                            end
                            `MB_FC_WR_SINGLE: begin
                                if (rx_cnt_r != `MB_FIXED_LEN) begin
                                    exc_r   <= `MB_EXC_VALUE;
                                    state_r <= S_BUILD;
                                end else begin
                                    state_r <= S_ISSUE;
                                end
                            end
                            `MB_FC_WR_MULTI: begin
                                if (qty_in == 16'h0000 || qty_in > `MB_MAX_WRITE
                                    || rxb[6] != {qty_in[6:0], 1'b0}
                                    || rx_cnt_r != len_multi) begin
                                    exc_r   <= `MB_EXC_VALUE;
                                    state_r <= S_BUILD;
                                end else begin
                                    state_r <= S_ISSUE;
                                end
                            end
                            default: begin
                                exc_r   <= `MB_EXC_FUNC;
                                state_r <= S_BUILD;
                            end
                        endcase
                    end
                end
                S_ISSUE: begin
                    par_cmd_r.req  <= 1'b1;
                    par_cmd_r.we   <= is_write;
                    par_cmd_r.addr <= addr_r + 16'h0001 + {8'h00, idx_r};
                    par_cmd_r.wdata <= (fc_r == `MB_FC_WR_SINGLE) ? qty_r
                        : {rxb[8'd7 + {idx_r[6:0], 1'b0}], rxb[8'd8 + {idx_r[6:0], 1'b0}]};
                    state_r <= S_WAIT;
                end
                S_WAIT: begin
                    if (par_resp.ack) begin
                        par_cmd_r.req <= 1'b0;
                        if (par_resp.busy) begin
                            exc_r   <= `MB_EXC_BUSY;
                            state_r <= S_BUILD;
                        end else if (par_resp.addr_err) begin
                            exc_r   <= `MB_EXC_ADDR;
                            state_r <= S_BUILD;
                        end else if (par_resp.val_err) begin
                            exc_r   <= `MB_EXC_VALUE;
                            state_r <= S_BUILD;
                        end else if (last_item) begin
                            state_r <= S_BUILD;
                        end else begin
                            idx_r   <= idx_r + 8'h01;
                            state_r <= S_ISSUE;
                        end
                    end
                end
                S_BUILD: begin
                    state_r <= S_SEND;
                end
                S_SEND: begin
                    if (tx_last && tx_ready) begin
                        state_r <= S_RECV;
                    end
                end
                default: begin
                    state_r <= S_RECV;
                end
            endcase
        end
    end

    // response image
    always_ff @(posedge sys_clk) begin
        if (state_r == S_WAIT && par_resp.ack && is_read) begin
            txb[8'd3 + {idx_r[6:0], 1'b0}] <= par_resp.rdata[15:8];
            txb[8'd4 + {idx_r[6:0], 1'b0}] <= par_resp.rdata[7:0];
        end else if (state_r == S_BUILD) begin
            txb[0] <= station_id_setting;
            if (exc_r != 8'h00) begin
                txb[1] <= fc_r | `MB_EXC_FLAG;
                txb[2] <= exc_r;
            end else if (is_read) begin
                txb[1] <= fc_r;
                txb[2] <= {qty_r[6:0], 1'b0};
            end else begin
                for (int i = 1; i < 6; i++) begin
                    txb[i] <= rxb[i];
                end
            end
        end
    end

    // transmit with crc low then high appended
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_valid_r <= 1'b0;
            tx_data_r  <= 8'h00;
            tx_ptr_r   <= 9'h000;
            tx_len_r   <= 9'h000;
            tx_crc_r   <= `MB_CRC_INIT;
        end else if (state_r == S_BUILD) begin
            tx_valid_r <= 1'b1;
            tx_data_r  <= station_id_setting;
            tx_ptr_r   <= 9'h000;
            tx_crc_r   <= `MB_CRC_INIT;
            if (exc_r != 8'h00) begin
                tx_len_r <= `MB_HDR_LEN;
            end else if (is_read) begin
                tx_len_r <= `MB_HDR_LEN + {qty_r[7:0], 1'b0};
            end else begin
                tx_len_r <= `MB_WR_RESP_LEN;
            end
        end else if (tx_hs) begin
            tx_crc_r <= tx_crc_nxt;
            tx_ptr_r <= tx_ptr_nxt;
            if (tx_last) begin
                tx_valid_r <= 1'b0;
            end else if (tx_ptr_nxt < tx_len_r) begin
                tx_data_r <= txb[tx_ptr_nxt[7:0]];
            end else if (tx_ptr_nxt == tx_len_r) begin
                tx_data_r <= tx_crc_nxt[7:0];
            end else begin
                tx_data_r <= tx_crc_nxt[15:8];
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_good_check(logic [7:0] f);
        state_r == S_CHECK && frame_ok && fc_in == f && rx_cnt_r == `MB_FIXED_LEN;
    endsequence

    a_resp_station: assert property (state_r == S_BUILD |=> tx_data == station_id_setting)
        else $error("response does not open with station id");
    a_par_addr: assert property (state_r == S_ISSUE |=> par_cmd.addr == $past(addr_r) + 16'h0001
        + {8'h00, $past(idx_r)})
        else $error("parameter address not field plus one plus index");
    a_rd_hold: assert property (s_good_check(`MB_FC_RD_HOLD) ##0 qty_in == 16'h0001
        |=> ##1 state_r == S_WAIT && !par_cmd.we)
        else $error("read holding request not issued as read");
    a_rd_input: assert property (s_good_check(`MB_FC_RD_INPUT) ##0 qty_in == 16'h0000
        |=> ##1 state_r == S_SEND ##0 tx_len_r == `MB_HDR_LEN)
        else $error("zero count input read not refused");
    a_wr_single: assert property (state_r == S_WAIT && fc_r == `MB_FC_WR_SINGLE
        |-> par_cmd.we && par_cmd.wdata == qty_r)
        else $error("single write data wrong");
    a_wr_multi: assert property (state_r == S_SEND && exc_r == 8'h00 && fc_r == `MB_FC_WR_MULTI
        |-> tx_len_r == `MB_WR_RESP_LEN)
        else $error("multi write response length wrong");
    a_exc_func: assert property (state_r == S_CHECK && frame_ok && fc_in == 8'h07
        |=> exc_r == `MB_EXC_FUNC)
        else $error("unsupported function not reported");
    a_exc_flag: assert property (state_r == S_SEND && exc_r != 8'h00 && tx_ptr_r == 9'h001
        |-> tx_data == (fc_r | `MB_EXC_FLAG))
        else $error("exception function byte lacks top bit");
    a_rd_count: assert property (state_r == S_SEND && exc_r == 8'h00 && is_read
        && tx_ptr_r == 9'h002 |-> tx_data == {qty_r[6:0], 1'b0})
        else $error("byte count not twice point count");
    a_drop_bad: assert property (state_r == S_CHECK && !frame_ok
        |=> state_r == S_RECV ##0 (!tx_valid) [*2])
        else $error("bad frame not dropped silently");
endmodule
